// ==== msf_top.v ====
// Function
// - Filter holds group 23:16, partition 15:0.
// - Group match off: ignore stored group.
// - Group match on: count equal group only.
// - Partition match off: ignore stored partition.
// - Partition match on: count equal partition.
// - Separate secure and non-secure filter copies.
// - Secure and non-secure pages reach own copies.
// - Selector holds 16-bit monitor index.
// - Route by stored index and access security.
// - Selector banked per security state.
// - Index beyond instances signals out-of-bounds.
// - Selector bits 27:24 pick resource instance.
// - Usage bit 31 is the not-ready flag.
// - Usage bits 30:0 give bytes occupied.
// - Separate secure and non-secure usage registers.
// - Usage monitor absent: reads zero, writes ignored.
// - Control bit 17 enables group match.
// - Control bit 16 enables partition match.
`timescale 1ns/1ps
`default_nettype none
`include "msf_regs.vh"

module msf_top (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // Register access port
    input wire reg_req_i,
    input wire reg_write_i,
    input wire reg_nonsecure_i,
    input wire [11:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    output wire reg_ready_o,
    output reg reg_ack_o,
    output reg reg_err_o,
    output reg [31:0] reg_rdata_o,
    // Selected instance, per security state
    output wire [15:0] sel_index_s_o,
    output wire [15:0] sel_index_ns_o,
    output wire [3:0] sel_ris_s_o,
    output wire [3:0] sel_ris_ns_o,
    // Cache usage monitors
    input wire [31:0] csu_usage_s_i,
    input wire [31:0] csu_usage_ns_i,
    output reg csu_write_o,
    output reg csu_write_ns_o,
    output reg [31:0] csu_wdata_o,
    // Traffic to be filtered
    input wire traffic_valid_i,
    input wire traffic_nonsecure_i,
    input wire [7:0] traffic_group_i,
    input wire [15:0] traffic_partition_i,
    output wire traffic_match_o
);

    // ****************************************************************
    // Decoding
    // ****************************************************************

    localparam K_SEL = 3'h0;
    localparam K_FLT = 3'h1;
    localparam K_CTL = 3'h2;
    localparam K_CSU = 3'h3;
    localparam K_BAD = 3'h4;

    function [2:0] reg_kind;
        input [11:0] a;
        begin
            if (a == `MSF_OFS_SEL)
                reg_kind = K_SEL;
            else if (a == `MSF_OFS_FLT)
                reg_kind = K_FLT;
            else if (a == `MSF_OFS_CTL)
                reg_kind = K_CTL;
            else if (a == `MSF_OFS_CSU)
                reg_kind = K_CSU;
            else
                reg_kind = K_BAD;
        end
    endfunction

    function idx_ok;
        input [15:0] idx;
        begin
            idx_ok = (idx < `MSF_INSTANCE_COUNT);
        end
    endfunction

    // ****************************************************************
    // Banked selector
    // ****************************************************************

    reg [15:0] sel_index_s;
    reg [15:0] sel_index_ns;
    reg [3:0] sel_ris_s;
    reg [3:0] sel_ris_ns;

    reg p1_valid;
    reg p1_write;
    reg p1_ns;
    reg p1_err;
    reg [2:0] p1_kind;

    wire take;
    wire [2:0] kind;
    wire [15:0] bus_idx;
    wire is_inst;
    wire oob;
    wire wr_ok;
    wire [`MSF_MEM_AW-1:0] bus_addr;

    // One access is in flight at a time; a new one waits for the answer.
    assign reg_ready_o = !p1_valid;
    assign take = reg_req_i & reg_ready_o;
    assign kind = reg_kind(reg_addr_i);

    // The frame of the access picks the bank.
    assign bus_idx = reg_nonsecure_i ? sel_index_ns : sel_index_s;

    assign is_inst = (kind == K_FLT) || (kind == K_CTL) ||
        ((kind == K_CSU) && `MSF_HAS_CSU);
    assign oob = is_inst & !idx_ok(bus_idx);
    assign wr_ok = take & reg_write_i & !oob;
    assign bus_addr = {reg_nonsecure_i, bus_idx[`MSF_IDX_W-1:0]};

    always @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            sel_index_s <= `MSF_SEL_RST;
            sel_index_ns <= `MSF_SEL_RST;
            sel_ris_s <= `MSF_RIS_RST;
            sel_ris_ns <= `MSF_RIS_RST;
        end
        else if (wr_ok && (kind == K_SEL) && `MSF_HAS_MON)
        begin
            if (reg_nonsecure_i)
            begin
                sel_index_ns <= reg_wdata_i[`MSF_IDX_MSB:`MSF_IDX_LSB];
                if (`MSF_HAS_RIS)
                    sel_ris_ns <= reg_wdata_i[`MSF_RIS_MSB:`MSF_RIS_LSB];
            end
            else
            begin
                sel_index_s <= reg_wdata_i[`MSF_IDX_MSB:`MSF_IDX_LSB];
                if (`MSF_HAS_RIS)
                    sel_ris_s <= reg_wdata_i[`MSF_RIS_MSB:`MSF_RIS_LSB];
            end
        end
    end

    assign sel_index_s_o = sel_index_s;
    assign sel_index_ns_o = sel_index_ns;
    assign sel_ris_s_o = sel_ris_s;
    assign sel_ris_ns_o = sel_ris_ns;

    // ****************************************************************
    // Filter and match-enable storage
    // ****************************************************************

    wire mem_we_flt;
    wire mem_we_ctl;
    wire [`MSF_WORD_W-1:0] mem_wdata;
    wire [`MSF_WORD_W-1:0] mem_rd_a;
    wire [`MSF_WORD_W-1:0] mem_rd_b;
    wire [15:0] trf_idx;
    wire [`MSF_MEM_AW-1:0] trf_addr;

    // Only the defined fields are stored, so reserved bits stay zero.
    assign mem_we_flt = wr_ok & (kind == K_FLT) & `MSF_HAS_MON;
    assign mem_we_ctl = wr_ok & (kind == K_CTL) & `MSF_HAS_MON;
    assign mem_wdata = {reg_wdata_i[`MSF_GM_BIT],
                        reg_wdata_i[`MSF_PM_BIT],
                        reg_wdata_i[`MSF_GRP_MSB:`MSF_PART_LSB]};

    assign trf_idx = traffic_nonsecure_i ? sel_index_ns : sel_index_s;
    assign trf_addr = {traffic_nonsecure_i, trf_idx[`MSF_IDX_W-1:0]};

    msf_filter_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .we_flt_i(mem_we_flt),
        .we_ctl_i(mem_we_ctl),
        .waddr_i(bus_addr),
        .wdata_i(mem_wdata),
        .raddr_a_i(bus_addr),
        .raddr_b_i(trf_addr),
        .rdata_a_o(mem_rd_a),
        .rdata_b_o(mem_rd_b)
    );

    // ****************************************************************
    // Traffic matching
    // ****************************************************************

    reg t1_valid;
    reg [7:0] t1_group;
    reg [15:0] t1_part;

    // Labels wait one cycle for the filter word of the selected monitor.
    always @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            t1_valid <= 1'b0;
            t1_group <= 8'h00;
            t1_part <= 16'h0000;
        end
        else
        begin
            t1_valid <= traffic_valid_i & idx_ok(trf_idx) & `MSF_HAS_MON;
            t1_group <= traffic_group_i;
            t1_part <= traffic_partition_i;
        end
    end

    msf_matcher u_match (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .valid_i(t1_valid),
        .group_i(t1_group),
        .partition_i(t1_part),
        .word_i(mem_rd_b),
        .match_o(traffic_match_o)
    );

    // ****************************************************************
    // Access pipeline and usage write-through
    // ****************************************************************

    always @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            p1_valid <= 1'b0;
            p1_write <= 1'b0;
            p1_ns <= 1'b0;
            p1_err <= 1'b0;
            p1_kind <= K_SEL;
            csu_write_o <= 1'b0;
            csu_write_ns_o <= 1'b0;
            csu_wdata_o <= 32'h00000000;
        end
        else
        begin
            p1_valid <= take;
            if (take)
            begin
                p1_write <= reg_write_i;
                p1_ns <= reg_nonsecure_i;
                p1_err <= oob | (kind == K_BAD);
                p1_kind <= kind;
            end
            csu_write_o <= wr_ok & (kind == K_CSU) & `MSF_HAS_CSU;
            if (wr_ok && (kind == K_CSU))
            begin
                csu_write_ns_o <= reg_nonsecure_i;
                csu_wdata_o <= reg_wdata_i;
            end
        end
    end

    // ****************************************************************
    // Read data and answer
    // ****************************************************************

    reg [31:0] next_rdata;
    reg [31:0] usage;

    always @*
    begin
        usage = p1_ns ? csu_usage_ns_i : csu_usage_s_i;
        next_rdata = 32'h00000000;
        case (p1_kind)
            K_SEL:
            begin
                if (p1_ns)
                    next_rdata = {4'h0, sel_ris_ns, 8'h00, sel_index_ns};
                else
                    next_rdata = {4'h0, sel_ris_s, 8'h00, sel_index_s};
            end
            K_FLT:
                next_rdata = {8'h00, mem_rd_a[`MSF_GRP_MSB:`MSF_PART_LSB]};
            K_CTL:
                next_rdata = {14'h0000, mem_rd_a[`MSF_W_GM],
                              mem_rd_a[`MSF_W_PM], 16'h0000};
            K_CSU:
            begin
                if (`MSF_HAS_CSU)
                    next_rdata = {usage[`MSF_NOT_READY_FLAG_BIT],
                                  usage[`MSF_VAL_MSB:0]};
            end
            default:
                next_rdata = 32'h00000000;
        endcase
        // Writes and refused accesses return zero data.
        if (p1_write || p1_err || !`MSF_HAS_MON)
            next_rdata = 32'h00000000;
    end

    always @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            reg_ack_o <= 1'b0;
            reg_err_o <= 1'b0;
            reg_rdata_o <= 32'h00000000;
        end
        else
        begin
            reg_ack_o <= p1_valid;
            reg_err_o <= p1_valid & p1_err;
            reg_rdata_o <= p1_valid ? next_rdata : 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// ==== msf_regs.vh ====
`ifndef MSF_REGS_VH
`define MSF_REGS_VH

// Register offsets inside each feature page frame.
`define MSF_OFS_SEL 12'h800
`define MSF_OFS_FLT 12'h820
`define MSF_OFS_CTL 12'h828
`define MSF_OFS_CSU 12'h840

// Selector fields.
`define MSF_IDX_MSB 15
`define MSF_IDX_LSB 0
`define MSF_RIS_MSB 27
`define MSF_RIS_LSB 24

// Filter fields.
`define MSF_GRP_MSB 23
`define MSF_GRP_LSB 16
`define MSF_PART_MSB 15
`define MSF_PART_LSB 0

// Control fields held by this block.
`define MSF_GM_BIT 17
`define MSF_PM_BIT 16

// Usage register fields.
`define MSF_NOT_READY_FLAG_BIT 31
`define MSF_VAL_MSB 30

// Stored filter word: group match, partition match, group, partition.
`define MSF_W_GM 25
`define MSF_W_PM 24
`define MSF_WORD_W 26

// Reset values.
`define MSF_SEL_RST 16'h0000
`define MSF_RIS_RST 4'h0
`define MSF_WORD_RST 26'h0000000

// Implemented features and monitor instances.
`define MSF_HAS_MON 1'b1
`define MSF_HAS_CSU 1'b1
`define MSF_HAS_RIS 1'b1
`define MSF_INSTANCE_COUNT 16'h0008
`define MSF_IDX_W 3
`define MSF_MEM_AW 4
`define MSF_MEM_DEPTH 16

`endif

// ==== msf_filter_mem.v ====
`timescale 1ns/1ps
`default_nettype none
`include "msf_regs.vh"

module msf_filter_mem (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // Write port
    input wire we_flt_i,
    input wire we_ctl_i,
    input wire [`MSF_MEM_AW-1:0] waddr_i,
    input wire [`MSF_WORD_W-1:0] wdata_i,
    // Read ports
    input wire [`MSF_MEM_AW-1:0] raddr_a_i,
    input wire [`MSF_MEM_AW-1:0] raddr_b_i,
    output reg [`MSF_WORD_W-1:0] rdata_a_o,
    output reg [`MSF_WORD_W-1:0] rdata_b_o
);

    reg [`MSF_WORD_W-1:0] mem [0:`MSF_MEM_DEPTH-1];
    integer i;

    // The filter and control fields of a word are written separately.
    always @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            for (i = 0; i < `MSF_MEM_DEPTH; i = i + 1)
                mem[i] <= `MSF_WORD_RST;
            rdata_a_o <= `MSF_WORD_RST;
            rdata_b_o <= `MSF_WORD_RST;
        end
        else
        begin
            if (we_flt_i)
                mem[waddr_i][`MSF_GRP_MSB:`MSF_PART_LSB] <= wdata_i[`MSF_GRP_MSB:`MSF_PART_LSB];
            if (we_ctl_i)
                mem[waddr_i][`MSF_W_GM:`MSF_W_PM] <= wdata_i[`MSF_W_GM:`MSF_W_PM];
            rdata_a_o <= mem[raddr_a_i];
            rdata_b_o <= mem[raddr_b_i];
        end
    end

endmodule
`default_nettype wire

// ==== msf_matcher.v ====
`timescale 1ns/1ps
`default_nettype none
`include "msf_regs.vh"

module msf_matcher (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // Traffic labels and stored filter
    input wire valid_i,
    input wire [7:0] group_i,
    input wire [15:0] partition_i,
    input wire [`MSF_WORD_W-1:0] word_i,
    // Result
    output reg match_o
);

    wire group_ok;
    wire part_ok;

    // A clear enable makes the stored value irrelevant.
    assign group_ok = !word_i[`MSF_W_GM] ||
        (group_i == word_i[`MSF_GRP_MSB:`MSF_GRP_LSB]);
    assign part_ok = !word_i[`MSF_W_PM] ||
        (partition_i == word_i[`MSF_PART_MSB:`MSF_PART_LSB]);

    always @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            match_o <= 1'b0;
        else
            match_o <= valid_i & group_ok & part_ok;
    end

endmodule
`default_nettype wire

// ==== msf_top_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module msf_top_monitor (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Register access port
    input wire logic reg_req_i,
    input wire logic reg_write_i,
    input wire logic reg_nonsecure_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_ready_o,
    input wire logic reg_ack_o,
    input wire logic reg_err_o,
    input wire logic [31:0] reg_rdata_o,
    // Selector state
    input wire logic [15:0] sel_index_s_o,
    input wire logic [15:0] sel_index_ns_o,
    input wire logic [3:0] sel_ris_s_o,
    // Traffic
    input wire logic traffic_valid_i,
    input wire logic traffic_match_o
);
    // ****************************************
    // Helper logic and properties
    // ****************************************
    // The answer always lands on the second edge; the windows also span the third.
    wire take = reg_req_i && reg_ready_o;
    wire [15:0] bank_idx = reg_nonsecure_i ? sel_index_ns_o : sel_index_s_o;
    wire mapped = reg_addr_i == 12'h800 || reg_addr_i == 12'h820 ||
        reg_addr_i == 12'h828 || reg_addr_i == 12'h840;
    wire sel_wr_s = take && reg_write_i && !reg_nonsecure_i && reg_addr_i == 12'h800;
    wire sel_wr_ns = take && reg_write_i && reg_nonsecure_i && reg_addr_i == 12'h800;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sel_write_a: assert property (sel_wr_s |=>
        sel_index_s_o == $past(reg_wdata_i[15:0]) &&
        sel_ris_s_o == $past(reg_wdata_i[27:24])) else $error("selector write not stored");
    sel_bank_a: assert property (sel_wr_ns |=>
        $stable(sel_index_s_o) && $stable(sel_ris_s_o))
        else $error("non-secure write changed secure selector");
    oob_err_a: assert property (take && reg_addr_i == 12'h820 && bank_idx >= 16'h0008
        |-> ##[2:3] reg_ack_o && reg_err_o && reg_rdata_o == 32'h0)
        else $error("index not refused");
    unmapped_err_a: assert property (take && !mapped |-> ##[2:3] reg_ack_o && reg_err_o)
        else $error("unmapped offset answered without error");
    sel_rsv_a: assert property (take && !reg_write_i && reg_addr_i == 12'h800
        |-> ##[2:3] reg_ack_o && reg_rdata_o[31:28] == 4'h0 && reg_rdata_o[23:16] == 8'h00)
        else $error("selector reserved bits not zero");
    flt_rsv_a: assert property (take && !reg_write_i && reg_addr_i == 12'h820
        |-> ##[2:3] reg_ack_o && reg_rdata_o[31:24] == 8'h00)
        else $error("filter reserved bits not zero");
    ack_pulse_a: assert property (reg_ack_o |=> !reg_ack_o)
        else $error("answer lasted more than one cycle");
    match_cause_a: assert property (traffic_match_o |->
        $past(traffic_valid_i, 2) || $past(traffic_valid_i, 3))
        else $error("match without beat");
    ack_time_a: assert property (take |=> !reg_ready_o ##1 (reg_ready_o && reg_ack_o))
        else $error("answer not two cycles after request");

    cover property (sel_wr_s);
    cover property (reg_ack_o && reg_err_o);
    cover property (traffic_match_o);
endmodule

`default_nettype wire

// ==== msf_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module msf_top_tb;
    // ****************************************
    // Stimulus and observation
    // ****************************************
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic reg_req_i = 1'b0;
    logic reg_write_i = 1'b0;
    logic reg_nonsecure_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] csu_usage_s_i = 32'h8000_1234;
    logic [31:0] csu_usage_ns_i = 32'h0000_00AB;
    logic traffic_valid_i = 1'b0;
    logic traffic_nonsecure_i = 1'b0;
    logic [7:0] traffic_group_i = 8'h00;
    logic [15:0] traffic_partition_i = 16'h0000;
    wire reg_ready_o, reg_ack_o, reg_err_o, csu_write_o, csu_write_ns_o, traffic_match_o;
    wire [31:0] reg_rdata_o, csu_wdata_o;
    wire [15:0] sel_index_s_o, sel_index_ns_o;
    wire [3:0] sel_ris_s_o, sel_ris_ns_o;
    int err_total = 0;
    int n_tests = 0;
    logic [31:0] rd, cwd;
    logic er, cw, cwn;

    always #50 ref_clk_i = ~ref_clk_i;

    msf_top uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_req_i(reg_req_i),
        .reg_write_i(reg_write_i), .reg_nonsecure_i(reg_nonsecure_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_ready_o(reg_ready_o), .reg_ack_o(reg_ack_o),
        .reg_err_o(reg_err_o), .reg_rdata_o(reg_rdata_o), .sel_index_s_o(sel_index_s_o),
        .sel_index_ns_o(sel_index_ns_o), .sel_ris_s_o(sel_ris_s_o), .sel_ris_ns_o(sel_ris_ns_o),
        .csu_usage_s_i(csu_usage_s_i), .csu_usage_ns_i(csu_usage_ns_i),
        .csu_write_o(csu_write_o), .csu_write_ns_o(csu_write_ns_o), .csu_wdata_o(csu_wdata_o),
        .traffic_valid_i(traffic_valid_i), .traffic_nonsecure_i(traffic_nonsecure_i),
        .traffic_group_i(traffic_group_i), .traffic_partition_i(traffic_partition_i),
        .traffic_match_o(traffic_match_o));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One access: request held through the taking edge, answer awaited for a bounded time.
    task automatic acc(input logic ns, wr, input logic [11:0] a, input logic [31:0] d = 32'h0);
        int i;
        @(posedge ref_clk_i);
        reg_req_i <= 1'b1;
        reg_write_i <= wr;
        reg_nonsecure_i <= ns;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_req_i <= 1'b0;
        cw = 1'b0;
        rd = 32'hx;
        er = 1'bx;
        for (i = 0; i < 6; i++)
        begin
            #1;
            if (csu_write_o === 1'b1)
            begin
                cw = 1'b1;
                cwn = csu_write_ns_o;
                cwd = csu_wdata_o;
            end
            if (reg_ack_o === 1'b1)
            begin
                rd = reg_rdata_o;
                er = reg_err_o;
                break;
            end
            @(posedge ref_clk_i);
        end
        check("answer", er !== 1'bx, 1'b1);
    endtask

    // One traffic beat; a match is looked for during the following four cycles.
    task automatic beat(input logic ns, input logic [7:0] g, input logic [15:0] p, input logic e);
        logic seen;
        seen = 1'b0;
        @(posedge ref_clk_i);
        traffic_valid_i <= 1'b1;
        traffic_nonsecure_i <= ns;
        traffic_group_i <= g;
        traffic_partition_i <= p;
        @(posedge ref_clk_i);
        traffic_valid_i <= 1'b0;
        repeat (4)
        begin
            #1;
            if (traffic_match_o === 1'b1)
                seen = 1'b1;
            @(posedge ref_clk_i);
        end
        check("match", seen, e);
    endtask

    task automatic t_sel();
        check("idx_s reset", sel_index_s_o, 32'h0);
        acc(0, 1, 12'h800, 32'hFFFF_FFFF);
        check("idx_s", sel_index_s_o, 32'h0000_FFFF);
        check("ris_s", sel_ris_s_o, 32'h0000_000F);
        check("idx_ns kept", sel_index_ns_o, 32'h0);
        acc(0, 0, 12'h800);
        check("sel_s read", rd, 32'h0F00_FFFF);
        acc(1, 1, 12'h800, 32'h0300_0005);
        check("idx_s kept", sel_index_s_o, 32'h0000_FFFF);
        acc(1, 0, 12'h800);
        check("sel_ns read", rd, 32'h0300_0005);
        check("idx_ns", sel_index_ns_o, 32'h0000_0005);
        check("ris_ns", sel_ris_ns_o, 32'h0000_0003);
    endtask

    task automatic t_flt();
        acc(0, 1, 12'h800, 32'h2);
        acc(1, 1, 12'h800, 32'h2);
        acc(0, 1, 12'h820, 32'hFFFF_FFFF);
        acc(0, 0, 12'h820);
        check("flt_s", rd, 32'h00FF_FFFF);
        acc(1, 0, 12'h820);
        check("flt_ns clean", rd, 32'h0);
        acc(1, 1, 12'h820, 32'h0012_3456);
        acc(1, 0, 12'h820);
        check("flt_ns", rd, 32'h0012_3456);
        acc(0, 0, 12'h820);
        check("flt_s kept", rd, 32'h00FF_FFFF);
        acc(0, 1, 12'h800, 32'h3);
        acc(0, 0, 12'h820);
        check("flt_s idx3", rd, 32'h0);
    endtask

    task automatic t_oob();
        acc(0, 1, 12'h800, 32'h8);
        acc(0, 1, 12'h820, 32'h1);
        check("oob wr err", er, 1'b1);
        acc(0, 0, 12'h820);
        check("oob rd err", er, 1'b1);
        check("oob rd data", rd, 32'h0);
        beat(0, 8'h00, 16'h0000, 1'b0);
        acc(0, 1, 12'h800, 32'h7);
        acc(0, 0, 12'h820);
        check("idx7 err", er, 1'b0);
        check("idx7 data", rd, 32'h0);
        acc(0, 0, 12'h804);
        check("unmapped err", er, 1'b1);
    endtask

    task automatic t_csu();
        acc(0, 0, 12'h840);
        check("csu_s", rd, 32'h8000_1234);
        acc(1, 0, 12'h840);
        check("csu_ns", rd, 32'h0000_00AB);
        @(posedge ref_clk_i);
        csu_usage_s_i <= 32'h0000_5678;
        acc(0, 0, 12'h840);
        check("csu_s new", rd, 32'h0000_5678);
        acc(1, 1, 12'h840, 32'h0000_0777);
        check("csu pulse", cw, 1'b1);
        check("csu bank", cwn, 1'b1);
        check("csu data", cwd, 32'h0000_0777);
    endtask

    task automatic t_match();
        logic [1:0] m;
        acc(0, 1, 12'h800, 32'h2);
        acc(0, 1, 12'h820, 32'h005A_1234);
        for (int i = 0; i < 4; i++)
        begin
            m = i[1:0];
            acc(0, 1, 12'h828, {14'h0, m, 16'h0});
            acc(0, 0, 12'h828);
            check("ctl", rd, {14'h0, m, 16'h0});
            beat(0, 8'h5A, 16'h1234, 1'b1);
            beat(0, 8'h5B, 16'h1234, !m[1]);
            beat(0, 8'h5A, 16'h1235, !m[0]);
            beat(0, 8'h5B, 16'h1235, m == 2'b00);
        end
        beat(1, 8'h00, 16'h0000, 1'b1);
        acc(1, 1, 12'h828, 32'h0003_0000);
        beat(1, 8'h12, 16'h3456, 1'b1);
        beat(1, 8'h5A, 16'h1234, 1'b0);
    endtask

    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_sel();
        t_flt();
        t_oob();
        t_csu();
        t_match();
        print_verdict();
    end

    // The tests take about 240 cycles; thirty thousand means a hang.
    initial
    begin
        #3000000;
        err_total++;
        print_verdict();
    end
endmodule

bind msf_top msf_top_monitor u_mon (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .reg_req_i(reg_req_i), .reg_write_i(reg_write_i), .reg_nonsecure_i(reg_nonsecure_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_ready_o(reg_ready_o),
    .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .reg_rdata_o(reg_rdata_o),
    .sel_index_s_o(sel_index_s_o), .sel_index_ns_o(sel_index_ns_o),
    .sel_ris_s_o(sel_ris_s_o), .traffic_valid_i(traffic_valid_i),
    .traffic_match_o(traffic_match_o));

`default_nettype wire
